/* File: include/dmairq_evt_if.sv */
// Carrier between the bus front end and the channel 0 flag keeper.
// Assumes both ends run on the same clock.

`timescale 1ns/1ps

interface dmairq_evt_if;
  logic transfer_error_event;
  logic half_transfer_event;
  logic transfer_complete_event;
  logic clear_strobe;
  logic flag;

  modport ctl
  (
    output transfer_error_event,
    output half_transfer_event,
    output transfer_complete_event,
    output clear_strobe,
    input flag
  );

  modport keeper
  (
    input transfer_error_event,
    input half_transfer_event,
    input transfer_complete_event,
    input clear_strobe,
    output flag
  );
endinterface

/* File: include/dmairq_pkg.sv */
// Constants and types shared by the DMA event status and flag clear block.
// Assumes a 32-bit AHB-Lite system bus running on the block's own clock.

package dmairq_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int DMAIRQ_WIN_BITS = 12;
  localparam logic [31:0] DMAIRQ_BASE_ADDR = 32'hA0000000;
  localparam logic [DMAIRQ_WIN_BITS-1:0] DMAIRQ_OFS_STATUS = 12'h000;
  localparam logic [DMAIRQ_WIN_BITS-1:0] DMAIRQ_OFS_CLEAR = 12'h004;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int DMAIRQ_CH0_FLAG_BIT = 0;
  localparam logic [31:0] DMAIRQ_STATUS_RST = 32'h00000000;
  localparam logic [31:0] DMAIRQ_CLEAR_RST = 32'h00000000;
  localparam logic DMAIRQ_FLAG_RST = 1'h0;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] DMAIRQ_HSIZE_WORD = 3'h2;
  localparam logic DMAIRQ_HRESP_OKAY = 1'h0;
  localparam logic DMAIRQ_HRESP_ERROR = 1'h1;

  // ----------------------------------------------------------------
  // Response sequencer, Gray coded along OKAY, ERR1, ERR2
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    DMAIRQ_RSP_OKAY = 2'h0,
    DMAIRQ_RSP_ERR1 = 2'h1,
    DMAIRQ_RSP_ERR2 = 2'h3
  } dmairq_rsp_e;

  function automatic logic dmairq_offset_hit(input logic [DMAIRQ_WIN_BITS-1:0] ofs,
                                             input logic [DMAIRQ_WIN_BITS-1:0] reg_ofs);
    dmairq_offset_hit = (ofs == reg_ofs);
  endfunction

endpackage

/* File: tb/dmairq_asserts.sv */
// Checker for the DMA event status and flag clear block.
// Assumes it is bound to dmairq_top, all signals on clk.
`timescale 1ns/1ps
module dmairq_asserts
  import dmairq_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = DMAIRQ_BASE_ADDR
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic transfer_error_event,
  input wire logic half_transfer_event,
  input wire logic transfer_complete_event,
  input wire logic chan0_any_event_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic tk = hsel && hready && htrans[1];
  wire logic legal = hsize == DMAIRQ_HSIZE_WORD && haddr[1:0] == 2'h0 && haddr[31:12] == BASE_ADDR[31:12];
  wire logic ok = tk && legal;
  wire logic at_st = ok && haddr[11:0] == DMAIRQ_OFS_STATUS;
  wire logic at_cl = ok && haddr[11:0] == DMAIRQ_OFS_CLEAR;
  wire logic ev = transfer_error_event || half_transfer_event || transfer_complete_event;
  logic clw_reg;
  logic stw_reg;
  // Data phase markers; the clear strobe acts one cycle after the address
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      clw_reg <= 1'h0;
      stw_reg <= 1'h0;
    end
    else
    begin
      clw_reg <= at_cl && hwrite;
      stw_reg <= at_st && hwrite;
    end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_err;
    !hreadyout && hresp ##1 hreadyout && hresp;
  endsequence
  property p_set; ev |=> chan0_any_event_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr; clw_reg && hwdata[0] && !ev |=> !chan0_any_event_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_keep; clw_reg && !hwdata[0] && !ev |=> $stable(chan0_any_event_flag); endproperty
  a_keep: assert property (p_keep) else $error("zero clear changed flag");
  property p_stw; stw_reg && !ev |=> $stable(chan0_any_event_flag); endproperty
  a_stw: assert property (p_stw) else $error("status write changed flag");
  property p_rd; at_st && !hwrite |=> hrdata == {31'h0, $past(chan0_any_event_flag)}; endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
  property p_rdc; at_cl && !hwrite |=> hrdata == 32'h0; endproperty
  a_rdc: assert property (p_rdc) else $error("clear read not zero");
  property p_err; tk && !legal |=> s_err; endproperty
  a_err: assert property (p_err) else $error("no error response");
  property p_ok; ok |=> hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("no okay response");
endmodule
bind dmairq_top dmairq_asserts #(.BASE_ADDR(BASE_ADDR)) u_chk
(
  .clk(clk),
  .nrst(nrst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .transfer_error_event(transfer_error_event),
  .half_transfer_event(half_transfer_event),
  .transfer_complete_event(transfer_complete_event),
  .chan0_any_event_flag(chan0_any_event_flag)
);

/* File: tb/test_dma_irq_status_clear.sv */
// Self-checking bench for the DMA event status and flag clear block.
// Assumes the block is the only slave, so hready follows hreadyout.
`timescale 1ns/1ps
module test_dma_irq_status_clear;
  import dmairq_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] evt = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic flag;
  logic [31:0] rd;
  logic er;
  int cyc;
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [31:0] B = DMAIRQ_BASE_ADDR;
  always #2 clk = ~clk;
  dmairq_top uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .transfer_error_event(evt[0]), .half_transfer_event(evt[1]), .transfer_complete_event(evt[2]),
    .chan0_any_event_flag(flag));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  // Starts and ends 1 ns after an edge; no ready within four data cycles counts as a mismatch
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] wd);
    logic done;
    done = 1'h0;
    hsel = 1'h1;
    haddr = a;
    htrans = 2'h2;
    hwrite = w;
    hsize = sz;
    @(posedge clk);
    #1;
    hsel = 1'h0;
    htrans = 2'h0;
    hwdata = wd;
    er = 1'h0;
    cyc = 0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      er = er | hresp;
      rd = hrdata;
      cyc = i + 1;
      if (hreadyout === 1'h1)
      begin
        done = 1'h1;
        break;
      end
    end
    chk("ready", 32'h1, {31'h0, done});
    #1;
  endtask
  task automatic pulse(input int i);
    evt[i] = 1'h1;
    @(posedge clk);
    #1;
    evt = 3'h0;
    @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'h1;
    xfer(B, 1'h0, 3'h2, 32'h0);
    chk("status", 32'h0, rd);
    xfer(B + 32'h4, 1'h0, 3'h2, 32'h0);
    chk("clear read", 32'h0, rd);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      xfer(B + 32'h4, 1'h1, 3'h2, 32'hFFFFFFFE);
      chk("zero clear", 32'h1, {31'h0, flag});
      xfer(B, 1'h1, 3'h2, 32'hFFFFFFFF);
      chk("status write", 32'h1, {31'h0, flag});
      xfer(B + 32'h4, 1'h1, 3'h0, 32'h1);
      chk("byte resp", 32'h1, {31'h0, er});
      chk("byte cycles", 32'h2, 32'(cyc));
      xfer(B, 1'h0, 3'h2, 32'h0);
      chk("status set", 32'h1, rd);
      xfer(B + 32'h4, 1'h1, 3'h2, 32'h1);
      chk("cleared", 32'h0, {31'h0, flag});
      xfer(B, 1'h0, 3'h2, 32'h0);
      chk("status cleared", 32'h0, rd);
    end
    // Event lands in the clear's data phase, so the set must win
    pulse(2);
    fork
      xfer(B + 32'h4, 1'h1, 3'h2, 32'h1);
      begin
        @(posedge clk);
        #1;
        evt[1] = 1'h1;
        @(posedge clk);
        #1;
        evt = 3'h0;
      end
    join
    chk("set wins", 32'h1, {31'h0, flag});
    // Reset in mid-run must drop a pending flag
    nrst = 1'h0;
    @(posedge clk);
    #1;
    nrst = 1'h1;
    chk("flag after reset", 32'h0, {31'h0, flag});
    xfer(B, 1'h0, 3'h2, 32'h0);
    chk("status after reset", 32'h0, rd);
    xfer(B, 1'h0, 3'h1, 32'h0);
    chk("half resp", 32'h1, {31'h0, er});
    xfer(B + 32'h2, 1'h0, 3'h2, 32'h0);
    chk("unaligned resp", 32'h1, {31'h0, er});
    xfer(B ^ 32'h00001000, 1'h0, 3'h2, 32'h0);
    chk("outside resp", 32'h1, {31'h0, er});
    xfer(B + 32'h8, 1'h0, 3'h2, 32'h0);
    chk("inside resp", 32'h0, {31'h0, er});
    chk("inside cycles", 32'h1, 32'(cyc));
    chk("inside read", 32'h0, rd);
    final_report();
  end
  // Whole run is about 90 cycles; this limit leaves wide margin
  initial
  begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule

/* File: verilog/dmairq_flag.sv */
// Channel 0 global event flag keeper.
// Assumes event pulses and the clear strobe come from logic on clk.

`timescale 1ns/1ps

module dmairq_flag
  import dmairq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  dmairq_evt_if.keeper evt
);

  logic flag_reg;
  logic flag_next;
  logic any_event;

  // ----------------------------------------------------------------
  // Set and clear
  // ----------------------------------------------------------------
  // Three distinct channel events all feed the one global flag
  assign any_event = evt.transfer_error_event | evt.half_transfer_event | evt.transfer_complete_event;
  // Set wins over a clear in the same cycle so no event is lost
  assign flag_next = any_event | (flag_reg & ~evt.clear_strobe);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_reg <= DMAIRQ_FLAG_RST;
    else
      flag_reg <= flag_next;
  end

  assign evt.flag = flag_reg;

endmodule

/* File: verilog/dmairq_top.sv */
// DMA event status register and flag clear register on an AHB-Lite slave port.
// Assumes HSEL comes from the system decoder and all ports are on clk.

`timescale 1ns/1ps

module dmairq_top
  import dmairq_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = dmairq_pkg::DMAIRQ_BASE_ADDR
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic transfer_error_event,
  input wire logic half_transfer_event,
  input wire logic transfer_complete_event,
  output logic chan0_any_event_flag
);

  import dmairq_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (BASE_ADDR[DMAIRQ_WIN_BITS-1:0] != '0)
  begin : g_base_check
    $error("BASE_ADDR must be aligned to the register window");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dmairq_evt_if evt();

  dmairq_rsp_e rsp_reg;
  dmairq_rsp_e rsp_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic hresp_reg;
  logic hresp_next;
  logic wr_clear_pend_reg;

  wire logic take;
  wire logic base_hit;
  wire logic size_ok;
  wire logic bad_access;
  wire logic [DMAIRQ_WIN_BITS-1:0] ofs;
  wire logic hit_status;
  wire logic hit_clear;
  wire logic rd_ok;
  wire logic wr_clear;
  wire logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  assign take = hsel & hready & htrans[1];
  assign base_hit = (haddr[31:DMAIRQ_WIN_BITS] == BASE_ADDR[31:DMAIRQ_WIN_BITS]);
  assign ofs = haddr[DMAIRQ_WIN_BITS-1:0];
  assign hit_status = dmairq_offset_hit(ofs, DMAIRQ_OFS_STATUS);
  assign hit_clear = dmairq_offset_hit(ofs, DMAIRQ_OFS_CLEAR);
  // Narrow or unaligned accesses get an ERROR response, which the core turns into a fault
  assign size_ok = (hsize == DMAIRQ_HSIZE_WORD) & (haddr[1:0] == 2'h0);
  assign bad_access = take & ~(base_hit & size_ok);
  assign rd_ok = take & ~bad_access & ~hwrite;
  // Writes to the status offset fall through here and touch nothing
  assign wr_clear = take & ~bad_access & hwrite & hit_clear;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign status_word = 32'(evt.flag) << DMAIRQ_CH0_FLAG_BIT;
  // Clear register and unused offsets read as zero
  assign hrdata_next = (rd_ok & hit_status) ? status_word : DMAIRQ_CLEAR_RST;

  // ----------------------------------------------------------------
  // Response sequencer
  // ----------------------------------------------------------------
  // ERROR takes two cycles so the master can cancel its next transfer
  always_comb
  begin
    rsp_next = rsp_reg;
    unique case (rsp_reg)
      DMAIRQ_RSP_OKAY: rsp_next = bad_access ? DMAIRQ_RSP_ERR1 : DMAIRQ_RSP_OKAY;
      DMAIRQ_RSP_ERR1: rsp_next = DMAIRQ_RSP_ERR2;
      DMAIRQ_RSP_ERR2: rsp_next = bad_access ? DMAIRQ_RSP_ERR1 : DMAIRQ_RSP_OKAY;
      default: rsp_next = DMAIRQ_RSP_OKAY;
    endcase
  end

  assign hreadyout_next = (rsp_next != DMAIRQ_RSP_ERR1);
  assign hresp_next = (rsp_next == DMAIRQ_RSP_OKAY) ? DMAIRQ_HRESP_OKAY : DMAIRQ_HRESP_ERROR;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_reg <= DMAIRQ_RSP_OKAY;
      hreadyout_reg <= 1'h1;
      hresp_reg <= DMAIRQ_HRESP_OKAY;
    end
    else
    begin
      rsp_reg <= rsp_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg <= hresp_next;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata_reg <= DMAIRQ_STATUS_RST;
      wr_clear_pend_reg <= 1'h0;
    end
    else
    begin
      hrdata_reg <= hrdata_next;
      wr_clear_pend_reg <= wr_clear;
    end
  end

  // ----------------------------------------------------------------
  // Flag keeper
  // ----------------------------------------------------------------
  assign evt.transfer_error_event = transfer_error_event;
  assign evt.half_transfer_event = half_transfer_event;
  assign evt.transfer_complete_event = transfer_complete_event;
  // Clear acts in the write data phase; a zero bit leaves the flag alone
  assign evt.clear_strobe = wr_clear_pend_reg & hwdata[DMAIRQ_CH0_FLAG_BIT];

  dmairq_flag u_flag
  (
    .clk(clk),
    .nrst(nrst),
    .evt(evt.keeper)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign chan0_any_event_flag = evt.flag;

endmodule
